/* File: rtl/tbwpt_pkg.sv */
package tbwpt_pkg;

	// widths of the counting structures, the bus and the interrupt bits
	localparam int TB_WIDTH = 18;
	localparam int WD_WIDTH = 2;
	localparam int PWM_WIDTH = 8;
	localparam int ADDR_WIDTH = 6;
	localparam int DATA_WIDTH = 32;
	localparam int IRQ_WIDTH = 3;

	// register byte offsets
	localparam logic [ADDR_WIDTH-1:0] OFS_TB_CTRL = 6'h00;
	localparam logic [ADDR_WIDTH-1:0] OFS_WD_CTRL = 6'h04;
	localparam logic [ADDR_WIDTH-1:0] OFS_PWM_CTRL = 6'h08;
	localparam logic [ADDR_WIDTH-1:0] OFS_PWM_HIGH = 6'h0c;
	localparam logic [ADDR_WIDTH-1:0] OFS_PWM_LOW = 6'h10;
	localparam logic [ADDR_WIDTH-1:0] OFS_IRQ_STAT = 6'h14;
	localparam logic [ADDR_WIDTH-1:0] OFS_IRQ_MASK = 6'h18;
	localparam logic [ADDR_WIDTH-1:0] OFS_TB_COUNT = 6'h1c;
	localparam logic [ADDR_WIDTH-1:0] OFS_STATE = 6'h20;

	// field positions
	localparam int TB_SEL_LSB = 0;
	localparam int TB_CLR_BIT = 2;
	localparam int WD_EN_BIT = 0;
	localparam int WD_SEL_LSB = 1;
	localparam int WD_CLR_BIT = 3;
	localparam int PWM_EN_BIT = 0;
	localparam int PWM_CLK_BIT = 1;
	localparam int IRQ_TB_BIT = 0;
	localparam int IRQ_PWM_BIT = 1;
	localparam int IRQ_WD_BIT = 2;
	localparam int ST_PWM_CNT_LSB = 0;
	localparam int ST_PWM_OUT_BIT = 8;
	localparam int ST_PWM_PH_LSB = 9;
	localparam int ST_WD_CNT_LSB = 12;

	// reset values and the last watchdog count
	localparam logic [1:0] SEL_RST = 2'h0;
	localparam logic [PWM_WIDTH-1:0] RELOAD_RST = 8'h00;
	localparam logic [IRQ_WIDTH-1:0] IRQ_RST = 3'h0;
	localparam logic [WD_WIDTH-1:0] WD_LAST = 2'h3;

	// count of low timebase bits that must be all ones for each tap
	localparam int TAP_BITS [4] = '{12, 14, 16, 18};
	localparam int PWM_TAP_BITS [2] = '{1, 4};

	// pwm phase encoding
	typedef enum logic [1:0] {
		PH_IDLE = 2'b00,
		PH_HIGH = 2'b01,
		PH_LOW = 2'b10
	} tbwpt_phase_type;

	// true on the count where the low bits of the timebase all read one
	function automatic logic tap_hit(input logic [TB_WIDTH-1:0] cnt, input int bits);
		logic [TB_WIDTH:0] full;
		logic [TB_WIDTH-1:0] mask;
		full = (TB_WIDTH + 1)'(1) << bits;
		mask = full[TB_WIDTH-1:0] - 18'h00001;
		return (cnt & mask) == mask;
	endfunction

endpackage

/* File: rtl/tbwpt_pwm.sv */
`timescale 1ns/1ps
module tbwpt_pwm (
	// clock and reset
	input wire logic mclk_i,
	input wire logic resetn_i,
	// control
	input wire logic enable_i,
	input wire logic tick_i,
	input wire logic [tbwpt_pkg::PWM_WIDTH-1:0] high_i,
	input wire logic [tbwpt_pkg::PWM_WIDTH-1:0] low_i,
	// results
	output logic pwm_o,
	output logic underflow_o,
	output logic [tbwpt_pkg::PWM_WIDTH-1:0] count_o,
	output logic [1:0] phase_o
);

	tbwpt_pkg::tbwpt_phase_type phase_ff;
	tbwpt_pkg::tbwpt_phase_type nxt_phase;
	logic [tbwpt_pkg::PWM_WIDTH-1:0] count_ff;
	logic [tbwpt_pkg::PWM_WIDTH-1:0] nxt_count;
	logic under_ff;
	logic nxt_under;

	// phase sequencing: load high width, count down, then low width, and repeat
	always_comb begin
		nxt_phase = phase_ff;
		nxt_count = count_ff;
		nxt_under = 1'b0;
		unique case (phase_ff)
			tbwpt_pkg::PH_IDLE: begin
				if (enable_i) begin
					nxt_phase = tbwpt_pkg::PH_HIGH;
					nxt_count = high_i;
				end
			end
			tbwpt_pkg::PH_HIGH: begin
				if (!enable_i) begin
					nxt_phase = tbwpt_pkg::PH_IDLE;
				end else if (tick_i) begin
					if (count_ff == '0) begin
						nxt_phase = tbwpt_pkg::PH_LOW;
						nxt_count = low_i;
						nxt_under = 1'b1;
					end else begin
						nxt_count = count_ff - 8'h01;
					end
				end
			end
			tbwpt_pkg::PH_LOW: begin
				if (!enable_i) begin
					nxt_phase = tbwpt_pkg::PH_IDLE;
				end else if (tick_i) begin
					if (count_ff == '0) begin
						nxt_phase = tbwpt_pkg::PH_HIGH;
						nxt_count = high_i;
						nxt_under = 1'b1;
					end else begin
						nxt_count = count_ff - 8'h01;
					end
				end
			end
			default: begin
				nxt_phase = tbwpt_pkg::PH_IDLE;
			end
		endcase
	end

	// state registers
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			phase_ff <= tbwpt_pkg::PH_IDLE;
			count_ff <= tbwpt_pkg::RELOAD_RST;
			under_ff <= 1'b0;
		end else begin
			phase_ff <= nxt_phase;
			count_ff <= nxt_count;
			under_ff <= nxt_under;
		end
	end

	// output high only through the high-width phase
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			pwm_o <= 1'b0;
		end else begin
			pwm_o <= (nxt_phase == tbwpt_pkg::PH_HIGH);
		end
	end

	assign underflow_o = under_ff;
	assign count_o = count_ff;
	assign phase_o = phase_ff;

endmodule

/* File: rtl/tbwpt_top.sv */
// The placing of the registers and the Avalon-MM interface to the registers were decided locally.
`timescale 1ns/1ps
module tbwpt_top (
	// clock and reset
	input wire logic mclk_i,
	input wire logic resetn_i,
	// avalon-mm slave
	input wire logic [tbwpt_pkg::ADDR_WIDTH-1:0] address_i,
	input wire logic read_i,
	input wire logic write_i,
	input wire logic [3:0] byteenable_i,
	input wire logic [tbwpt_pkg::DATA_WIDTH-1:0] writedata_i,
	output logic [tbwpt_pkg::DATA_WIDTH-1:0] readdata_o,
	output logic waitrequest_o,
	// pins and system outputs
	output logic pwm_o,
	output logic cpu_reset_o,
	output logic stab_tick_o,
	output logic irq_o
);

	// bus handshake
	logic ack_ff;
	logic wr_go;
	logic rd_go;
	logic [tbwpt_pkg::DATA_WIDTH-1:0] readdata_ff;
	logic [tbwpt_pkg::DATA_WIDTH-1:0] nxt_readdata;

	// register write strobes
	logic wr_tb_ctrl;
	logic wr_wd_ctrl;
	logic wr_pwm_ctrl;
	logic wr_pwm_high;
	logic wr_pwm_low;
	logic wr_irq_stat;
	logic wr_irq_mask;

	// control registers
	logic [1:0] tb_sel_ff;
	logic wd_en_ff;
	logic [1:0] wd_sel_ff;
	logic pwm_en_ff;
	logic pwm_clk_ff;
	logic [tbwpt_pkg::PWM_WIDTH-1:0] pwm_high_ff;
	logic [tbwpt_pkg::PWM_WIDTH-1:0] pwm_low_ff;
	logic [tbwpt_pkg::IRQ_WIDTH-1:0] irq_stat_ff;
	logic [tbwpt_pkg::IRQ_WIDTH-1:0] irq_mask_ff;
	logic [tbwpt_pkg::IRQ_WIDTH-1:0] irq_set;
	logic [tbwpt_pkg::IRQ_WIDTH-1:0] irq_clr;
	logic [tbwpt_pkg::IRQ_WIDTH-1:0] irq_pend;

	// timebase
	logic div_ff;
	logic [tbwpt_pkg::TB_WIDTH-1:0] tb_cnt_ff;
	logic tb_clr;
	logic tb_step;
	logic interval_tick;
	logic wd_tick;
	logic pwm_tick;
	logic stab_ff;

	// watchdog
	logic [tbwpt_pkg::WD_WIDTH-1:0] wd_cnt_ff;
	logic wd_clr;
	logic wd_expire;
	logic cpu_reset_ff;

	// pwm
	logic pwm_under;
	logic [tbwpt_pkg::PWM_WIDTH-1:0] pwm_count;
	logic [1:0] pwm_phase;

	// one wait cycle per access: waitrequest drops in the cycle after the request rises
	assign waitrequest_o = (read_i | write_i) & ~ack_ff;
	assign wr_go = write_i & ack_ff;
	assign rd_go = read_i & ~ack_ff;

	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			ack_ff <= 1'b0;
		end else begin
			ack_ff <= (read_i | write_i) & ~ack_ff;
		end
	end

	// write decode; every field sits in byte lane zero
	function automatic logic hit_wr(input logic [tbwpt_pkg::ADDR_WIDTH-1:0] ofs,
		input logic [tbwpt_pkg::ADDR_WIDTH-1:0] addr, input logic go, input logic be0);
		return go && be0 && (addr == ofs);
	endfunction

	// one strobe per register, each on the completing edge of a lane zero write
	assign wr_tb_ctrl = hit_wr(tbwpt_pkg::OFS_TB_CTRL, address_i, wr_go, byteenable_i[0]);
	assign wr_wd_ctrl = hit_wr(tbwpt_pkg::OFS_WD_CTRL, address_i, wr_go, byteenable_i[0]);
	assign wr_pwm_ctrl = hit_wr(tbwpt_pkg::OFS_PWM_CTRL, address_i, wr_go, byteenable_i[0]);
	assign wr_pwm_high = hit_wr(tbwpt_pkg::OFS_PWM_HIGH, address_i, wr_go, byteenable_i[0]);
	assign wr_pwm_low = hit_wr(tbwpt_pkg::OFS_PWM_LOW, address_i, wr_go, byteenable_i[0]);
	assign wr_irq_stat = hit_wr(tbwpt_pkg::OFS_IRQ_STAT, address_i, wr_go, byteenable_i[0]);
	assign wr_irq_mask = hit_wr(tbwpt_pkg::OFS_IRQ_MASK, address_i, wr_go, byteenable_i[0]);

	// timebase control: interval select and counter clear
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			tb_sel_ff <= tbwpt_pkg::SEL_RST;
		end else if (wr_tb_ctrl) begin
			tb_sel_ff <= writedata_i[tbwpt_pkg::TB_SEL_LSB +: 2];
		end
	end

	assign tb_clr = wr_tb_ctrl
		& writedata_i[tbwpt_pkg::TB_CLR_BIT];

	// watchdog enable: a one sets it, only reset takes it away
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			wd_en_ff <= 1'b0;
		end else if (wr_wd_ctrl && writedata_i[tbwpt_pkg::WD_EN_BIT]) begin
			wd_en_ff <= 1'b1;
		end
	end

	// watchdog tap select, frozen once the watchdog is armed
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			wd_sel_ff <= tbwpt_pkg::SEL_RST;
		end else if (wr_wd_ctrl && !wd_en_ff) begin
			wd_sel_ff <= writedata_i[tbwpt_pkg::WD_SEL_LSB +: 2];
		end
	end

	// software clear strobe
	assign wd_clr = wr_wd_ctrl
		& writedata_i[tbwpt_pkg::WD_CLR_BIT];

	// pwm enable
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			pwm_en_ff <= 1'b0;
		end else if (wr_pwm_ctrl) begin
			pwm_en_ff <= writedata_i[tbwpt_pkg::PWM_EN_BIT];
		end
	end

	// pwm count clock select
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			pwm_clk_ff <= 1'b0;
		end else if (wr_pwm_ctrl) begin
			pwm_clk_ff <= writedata_i[tbwpt_pkg::PWM_CLK_BIT];
		end
	end

	// pwm high-width reload, taken by the counter at its next reload
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			pwm_high_ff <= tbwpt_pkg::RELOAD_RST;
		end else if (wr_pwm_high) begin
			pwm_high_ff <= writedata_i[tbwpt_pkg::PWM_WIDTH-1:0];
		end
	end

	// pwm low-width reload
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			pwm_low_ff <= tbwpt_pkg::RELOAD_RST;
		end else if (wr_pwm_low) begin
			pwm_low_ff <= writedata_i[tbwpt_pkg::PWM_WIDTH-1:0];
		end
	end

	// interrupt mask
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			irq_mask_ff <= tbwpt_pkg::IRQ_RST;
		end else if (wr_irq_mask) begin
			irq_mask_ff <= writedata_i[tbwpt_pkg::IRQ_WIDTH-1:0];
		end
	end

	// divide the oscillator by two to form the count clock enable
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			div_ff <= 1'b0;
		end else if (tb_clr) begin
			div_ff <= 1'b0;
		end else begin
			div_ff <= ~div_ff;
		end
	end

	assign tb_step = div_ff;

	// free-running up counter; wraps from all ones to zero with no stop
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			tb_cnt_ff <= '0;
		end else if (tb_clr) begin
			tb_cnt_ff <= '0;
		end else if (tb_step) begin
			tb_cnt_ff <= tb_cnt_ff + 18'h00001;
		end
	end

	// tap decode: a tap fires on the count step that carries out of its low bits
	assign interval_tick = tb_step & tbwpt_pkg::tap_hit(tb_cnt_ff, tbwpt_pkg::TAP_BITS[tb_sel_ff]);
	assign wd_tick = tb_step & tbwpt_pkg::tap_hit(tb_cnt_ff, tbwpt_pkg::TAP_BITS[wd_sel_ff]);
	assign pwm_tick = tb_step & tbwpt_pkg::tap_hit(tb_cnt_ff, tbwpt_pkg::PWM_TAP_BITS[pwm_clk_ff]);

	// stabilization wait tick from the full wrap of the timebase
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			stab_ff <= 1'b0;
		end else begin
			stab_ff <= tb_step & tbwpt_pkg::tap_hit(tb_cnt_ff, tbwpt_pkg::TB_WIDTH);
		end
	end

	assign stab_tick_o = stab_ff;

	// watchdog: software clear wins over a tap step in the same cycle
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			wd_cnt_ff <= '0;
		end else if (wd_clr || !wd_en_ff) begin
			wd_cnt_ff <= '0;
		end else if (wd_tick) begin
			wd_cnt_ff <= wd_cnt_ff + 2'h1;
		end
	end

	// a tap step with the counter already at its last value means software was late
	assign wd_expire = wd_en_ff & ~wd_clr & wd_tick & (wd_cnt_ff == tbwpt_pkg::WD_LAST);

	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			cpu_reset_ff <= 1'b0;
		end else begin
			cpu_reset_ff <= wd_expire;
		end
	end

	assign cpu_reset_o = cpu_reset_ff;

	// pwm channel: high width then low width, each reload+1 ticks long
	tbwpt_pwm u_pwm (
		.mclk_i(mclk_i),
		.resetn_i(resetn_i),
		.enable_i(pwm_en_ff),
		.tick_i(pwm_tick),
		.high_i(pwm_high_ff),
		.low_i(pwm_low_ff),
		.pwm_o(pwm_o),
		.underflow_o(pwm_under),
		.count_o(pwm_count),
		.phase_o(pwm_phase)
	);

	// event collection for the sticky status bits
	always_comb begin
		irq_set = '0;
		irq_set[tbwpt_pkg::IRQ_TB_BIT] = interval_tick;
		irq_set[tbwpt_pkg::IRQ_PWM_BIT] = pwm_under;
		irq_set[tbwpt_pkg::IRQ_WD_BIT] = wd_expire;
	end

	assign irq_clr = wr_irq_stat
		? writedata_i[tbwpt_pkg::IRQ_WIDTH-1:0] : '0;

	// write one to clear; a new event in the clearing cycle keeps its bit set
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			irq_stat_ff <= tbwpt_pkg::IRQ_RST;
		end else begin
			irq_stat_ff <= (irq_stat_ff & ~irq_clr) | irq_set;
		end
	end

	// level interrupt from unmasked status
	assign irq_pend = irq_stat_ff & irq_mask_ff;
	assign irq_o = |irq_pend;

	// read mux; unmapped offsets read zero
	always_comb begin
		nxt_readdata = '0;
		unique case (address_i)
			tbwpt_pkg::OFS_TB_CTRL: begin
				nxt_readdata[tbwpt_pkg::TB_SEL_LSB +: 2] = tb_sel_ff;
			end
			tbwpt_pkg::OFS_WD_CTRL: begin
				nxt_readdata[tbwpt_pkg::WD_EN_BIT] = wd_en_ff;
				nxt_readdata[tbwpt_pkg::WD_SEL_LSB +: 2] = wd_sel_ff;
			end
			tbwpt_pkg::OFS_PWM_CTRL: begin
				nxt_readdata[tbwpt_pkg::PWM_EN_BIT] = pwm_en_ff;
				nxt_readdata[tbwpt_pkg::PWM_CLK_BIT] = pwm_clk_ff;
			end
			tbwpt_pkg::OFS_PWM_HIGH: begin
				nxt_readdata[tbwpt_pkg::PWM_WIDTH-1:0] = pwm_high_ff;
			end
			tbwpt_pkg::OFS_PWM_LOW: begin
				nxt_readdata[tbwpt_pkg::PWM_WIDTH-1:0] = pwm_low_ff;
			end
			tbwpt_pkg::OFS_IRQ_STAT: begin
				nxt_readdata[tbwpt_pkg::IRQ_WIDTH-1:0] = irq_stat_ff;
			end
			tbwpt_pkg::OFS_IRQ_MASK: begin
				nxt_readdata[tbwpt_pkg::IRQ_WIDTH-1:0] = irq_mask_ff;
			end
			tbwpt_pkg::OFS_TB_COUNT: begin
				nxt_readdata[tbwpt_pkg::TB_WIDTH-1:0] = tb_cnt_ff;
			end
			tbwpt_pkg::OFS_STATE: begin
				nxt_readdata[tbwpt_pkg::ST_PWM_CNT_LSB +: tbwpt_pkg::PWM_WIDTH] = pwm_count;
				nxt_readdata[tbwpt_pkg::ST_PWM_OUT_BIT] = pwm_o;
				nxt_readdata[tbwpt_pkg::ST_PWM_PH_LSB +: 2] = pwm_phase;
				nxt_readdata[tbwpt_pkg::ST_WD_CNT_LSB +: tbwpt_pkg::WD_WIDTH] = wd_cnt_ff;
			end
			default: begin
				nxt_readdata = '0;
			end
		endcase
	end

	// read data captured on the request's first cycle, held while ack stands
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			readdata_ff <= '0;
		end else if (rd_go) begin
			readdata_ff <= nxt_readdata;
		end
	end

	assign readdata_o = readdata_ff;

endmodule

/* File: verification/tb_timebase_watchdog_pwm_timers.sv */
`timescale 1ns/1ps
module tb_timebase_watchdog_pwm_timers;
	logic mclk_i, resetn_i, read_i, write_i, waitrequest_o, pwm_o, cpu_reset_o, stab_tick_o, irq_o;
	logic [tbwpt_pkg::ADDR_WIDTH-1:0] address_i;
	logic [3:0] byteenable_i;
	logic [tbwpt_pkg::DATA_WIDTH-1:0] writedata_i, readdata_o, q;
	int n_errors, samples_checked, n, hi, lo;

	tbwpt_top u_tbwpt_top (.mclk_i, .resetn_i, .address_i, .read_i, .write_i, .byteenable_i, .writedata_i,
		.readdata_o, .waitrequest_o, .pwm_o, .cpu_reset_o, .stab_tick_o, .irq_o);

	// 125 mhz clock
	initial begin
		mclk_i = 1'b0;
		forever #4 mclk_i = ~mclk_i;
	end

	// closing report
	task automatic stop_test();
		$display("errors %0d checks %0d", n_errors, samples_checked);
		if (n_errors == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_errors++;
			$display("unexpected %s expected %h seen %h", what, exp, got);
		end
	endtask

	// counts falling edges until the chosen output reaches a level
	task automatic wait_lvl(input int s, input logic v, input int lim, output int c);
		c = 0;
		while ((s == 0 ? pwm_o : s == 1 ? irq_o : cpu_reset_o) !== v) begin
			@(negedge mclk_i);
			c++;
			if (c > lim) begin
				check("wait", 0, 1);
				stop_test();
			end
		end
	endtask

	// one bus access, held until waitrequest is seen low at a rising edge
	task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d, input logic [3:0] be);
		int i;
		@(posedge mclk_i);
		read_i <= !wr;
		write_i <= wr;
		address_i <= a;
		writedata_i <= d;
		byteenable_i <= be;
		for (i = 0; i < 20; i++) begin
			@(posedge mclk_i);
			if (waitrequest_o === 1'b0)
				break;
		end
		if (i == 20) begin
			check("waitrequest", 1, 0);
			stop_test();
		end
		q = readdata_o;
		read_i <= 1'b0;
		write_i <= 1'b0;
	endtask

	task automatic wr(input logic [5:0] a, input logic [31:0] d);
		bus(1'b1, a, d, 4'h1);
	endtask

	task automatic rdc(input string nm, input logic [5:0] a, input logic [31:0] m, input logic [31:0] e);
		bus(1'b0, a, 32'h0, 4'h0);
		check(nm, q & m, e);
	endtask

	// reset values, lane gating, read back and unmapped place
	task automatic t_regs();
		rdc("high_rst", tbwpt_pkg::OFS_PWM_HIGH, 32'hffffffff, 32'h0);
		rdc("mask_rst", tbwpt_pkg::OFS_IRQ_MASK, 32'hffffffff, 32'h0);
		bus(1'b1, tbwpt_pkg::OFS_PWM_LOW, 32'h5a, 4'he);
		rdc("low_lane", tbwpt_pkg::OFS_PWM_LOW, 32'hffffffff, 32'h0);
		wr(tbwpt_pkg::OFS_PWM_HIGH, 32'ha5);
		rdc("high_rw", tbwpt_pkg::OFS_PWM_HIGH, 32'hffffffff, 32'ha5);
		wr(6'h3c, 32'hff);
		rdc("unmapped", 6'h3c, 32'hffffffff, 32'h0);
	endtask

	// widths of both phases for plain, extreme duty and slow clock settings
	task automatic t_pwm();
		logic [7:0] hv [3] = '{8'h02, 8'hff, 8'h00};
		logic [7:0] lv [3] = '{8'h05, 8'h00, 8'h00};
		int step [3] = '{4, 4, 32};
		for (int k = 0; k < 3; k++) begin
			wr(tbwpt_pkg::OFS_PWM_CTRL, 32'h0);
			wr(tbwpt_pkg::OFS_PWM_HIGH, {24'h0, hv[k]});
			wr(tbwpt_pkg::OFS_PWM_LOW, {24'h0, lv[k]});
			wr(tbwpt_pkg::OFS_PWM_CTRL, (k == 2) ? 32'h3 : 32'h1);
			wait_lvl(0, 1'b1, 100, n);
			wait_lvl(0, 1'b0, 9000, n);
			wait_lvl(0, 1'b1, 9000, n);
			wait_lvl(0, 1'b0, 9000, hi);
			wait_lvl(0, 1'b1, 9000, lo);
			check("high_width", hi, (hv[k] + 1) * step[k]);
			check("low_width", lo, (lv[k] + 1) * step[k]);
		end
		rdc("uf_stat", tbwpt_pkg::OFS_IRQ_STAT, 32'h2, 32'h2);
		check("irq_masked", irq_o, 0);
		wr(tbwpt_pkg::OFS_IRQ_MASK, 32'h2);
		@(negedge mclk_i);
		check("irq_open", irq_o, 1);
		wr(tbwpt_pkg::OFS_PWM_CTRL, 32'h0);
		wr(tbwpt_pkg::OFS_IRQ_STAT, 32'h2);
		rdc("uf_clear", tbwpt_pkg::OFS_IRQ_STAT, 32'h2, 32'h0);
		check("irq_clear", irq_o, 0);
		check("pwm_idle", pwm_o, 0);
		wr(tbwpt_pkg::OFS_IRQ_MASK, 32'h0);
	endtask

	// shortest interval tick after clearing the timebase
	task automatic t_tick();
		wr(tbwpt_pkg::OFS_IRQ_MASK, 32'h1);
		wr(tbwpt_pkg::OFS_TB_CTRL, 32'h4);
		rdc("tb_cleared", tbwpt_pkg::OFS_TB_COUNT, 32'h3fff8, 32'h0);
		wr(tbwpt_pkg::OFS_IRQ_STAT, 32'h1);
		@(negedge mclk_i);
		wait_lvl(1, 1'b1, 9000, n);
		check("tick_gap", n > 8150 && n < 8200, 1);
		wr(tbwpt_pkg::OFS_IRQ_STAT, 32'h1);
		@(negedge mclk_i);
		check("tick_clear", irq_o, 0);
		wr(tbwpt_pkg::OFS_IRQ_MASK, 32'h0);
	endtask

	// watchdog kept alive by clears, then left to expire
	task automatic t_wdog();
		logic seen;
		logic st;
		seen = 1'b0;
		st = 1'b0;
		wr(tbwpt_pkg::OFS_TB_CTRL, 32'h4);
		wr(tbwpt_pkg::OFS_WD_CTRL, 32'h1);
		repeat (3) begin
			repeat (12000) begin
				@(negedge mclk_i);
				seen |= cpu_reset_o;
				st |= stab_tick_o;
			end
			wr(tbwpt_pkg::OFS_WD_CTRL, 32'h9);
		end
		check("wd_kept", seen, 0);
		check("stab_quiet", st, 0);
		wait_lvl(2, 1'b1, 40000, n);
		check("wd_expiry", n > 3 * 8192 - 8 && n <= 4 * 8192 + 8, 1);
		rdc("wd_stat", tbwpt_pkg::OFS_IRQ_STAT, 32'h4, 32'h4);
	endtask

	// main sequence
	initial begin
		n_errors = 0;
		samples_checked = 0;
		resetn_i = 1'b0;
		read_i = 1'b0;
		write_i = 1'b0;
		address_i = '0;
		byteenable_i = 4'h0;
		writedata_i = '0;
		repeat (4) @(posedge mclk_i);
		resetn_i <= 1'b1;
		t_regs();
		t_pwm();
		t_tick();
		t_wdog();
		stop_test();
	end
endmodule

/* File: verification/tbwpt_properties.sv */
`timescale 1ns/1ps
// watches the bus handshake and the system outputs of the timer block
module tbwpt_checker (
	// clock and reset
	input wire logic mclk_i,
	input wire logic resetn_i,
	// register bus
	input wire logic [tbwpt_pkg::ADDR_WIDTH-1:0] address_i,
	input wire logic read_i,
	input wire logic write_i,
	input wire logic [tbwpt_pkg::DATA_WIDTH-1:0] readdata_o,
	input wire logic waitrequest_o,
	// pins and system outputs
	input wire logic pwm_o,
	input wire logic cpu_reset_o,
	input wire logic stab_tick_o,
	input wire logic irq_o
);
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!resetn_i);
	// every access waits exactly one cycle
	wait_one_a: assert property ((read_i || write_i) && waitrequest_o |=> !waitrequest_o)
		else $error("access waited more than one cycle");
	wait_cause_a: assert property (waitrequest_o |-> (read_i || write_i))
		else $error("wait raised without a request");
	// read data only moves when a read is captured
	rdata_hold_a: assert property (!read_i |=> $stable(readdata_o))
		else $error("read data moved without a read");
	unmapped_zero_a: assert property (read_i && waitrequest_o && address_i > 6'h20 |=> readdata_o == 32'h0)
		else $error("unmapped read not zero");
	// reset pulse and stabilization tick are one cycle and cannot repeat soon
	cpu_pulse_a: assert property (cpu_reset_o |=> !cpu_reset_o [*8])
		else $error("cpu reset pulse too long");
	stab_pulse_a: assert property (stab_tick_o |=> !stab_tick_o [*8])
		else $error("stabilization tick too long");
	// a low phase lasts at least one pwm tick of four clocks
	pwm_low_a: assert property ($fell(pwm_o) |=> !pwm_o [*3])
		else $error("pwm low phase too short");
	out_reset_a: assert property ($rose(resetn_i) |-> !pwm_o && !irq_o && !cpu_reset_o && !stab_tick_o)
		else $error("outputs active out of reset");
endmodule
bind tbwpt_top tbwpt_checker u_tbwpt_checker (.mclk_i(mclk_i), .resetn_i(resetn_i), .address_i(address_i),
	.read_i(read_i), .write_i(write_i), .readdata_o(readdata_o), .waitrequest_o(waitrequest_o),
	.pwm_o(pwm_o), .cpu_reset_o(cpu_reset_o), .stab_tick_o(stab_tick_o), .irq_o(irq_o));
